// ### core/bir_pkg.sv
// shared constants, types and helpers of the board interrupt router
package bir_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned PORT_W  = 32;
  localparam int unsigned LANES   = 4;
  localparam int unsigned ADDR_W  = 8;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_DIR    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IEN    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_POL    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TRIG   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CAUSE  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LANE   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STEER  = 8'h20;

  // ==========================================================
  // steering register fields
  localparam int unsigned STEER_PRI_LSB = 0;
  localparam int unsigned STEER_SEC_LSB = 8;

  // ==========================================================
  // pin positions of the board sources
  localparam int unsigned PIN_DOORBELL_FROM_CPU2 = 4;
  localparam int unsigned PIN_DOORBELL_TO_CPU2   = 5;
  localparam int unsigned PIN_PRI_SLOT_LO        = 6;
  localparam int unsigned PIN_PRI_SLOT_HI        = 9;
  localparam int unsigned PIN_SEC_SLOT_LO        = 10;
  localparam int unsigned PIN_SEC_SLOT_HI        = 13;
  localparam int unsigned PIN_PHY_MGMT_1         = 14;
  localparam int unsigned PIN_PHY_MGMT_2         = 15;
  localparam int unsigned PIN_SOUTHBRIDGE        = 22;
  localparam int unsigned PIN_DOORBELL_FROM_CPU1 = 30;
  localparam int unsigned PIN_DOORBELL_TO_CPU1   = 31;

  // ==========================================================
  // reset values
  localparam logic [PORT_W-1:0] RST_DIR   = 32'h0000_0000;
  localparam logic [PORT_W-1:0] RST_OUT   = 32'hFFFF_FFFF;
  localparam logic [PORT_W-1:0] RST_IEN   = 32'h0000_0000;
  // active low: doorbells 4/30, slot lines 6..13, phy lines 14/15
  localparam logic [PORT_W-1:0] RST_POL   = 32'h4000_FFD0;
  // edge: doorbells 4/30 and southbridge 22
  localparam logic [PORT_W-1:0] RST_TRIG  = 32'h4040_0010;
  localparam logic [LANES-1:0]  RST_PRI   = 4'h7;
  localparam logic [LANES-1:0]  RST_SEC   = 4'h8;
  localparam logic [PORT_W-1:0] RD_ZERO   = 32'h0000_0000;
  // idle level of the pulled-up pins
  localparam logic [PORT_W-1:0] RST_PIN   = 32'hFFFF_FFFF;

  // ==========================================================
  // types
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [3:0]        be;
    logic [PORT_W-1:0] wdata;
  } bir_bus_req_t;

  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] dout;
    logic [PORT_W-1:0] ien;
    logic [PORT_W-1:0] pol;
    logic [PORT_W-1:0] trig;
    logic [PORT_W-1:0] cause;
    logic [PORT_W-1:0] prev;
    logic [LANES-1:0]  lane;
    logic [LANES-1:0]  pri;
    logic [LANES-1:0]  sec;
    logic [PORT_W-1:0] rdata;
    logic              irq_pri;
    logic              irq_sec;
  } bir_state_t;

  // ==========================================================
  // byte lane mask from byte enables
  function automatic logic [PORT_W-1:0] bir_lane_mask(input logic [3:0] be);
    bir_lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // byte lane merge of a write into a register
  function automatic logic [PORT_W-1:0] bir_merge(input logic [PORT_W-1:0] old,
                                                  input logic [PORT_W-1:0] wd,
                                                  input logic [3:0]        be);
    bir_merge = (old & ~bir_lane_mask(be)) | (wd & bir_lane_mask(be));
  endfunction

endpackage

// ### core/bir_sync2.sv
// two flop synchroniser for the pin port inputs
`timescale 1ns/100ps
`default_nettype none

module bir_sync2
#(
  parameter int unsigned WIDTH = 32
)
(
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // ==========================================================
  // one chain per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clock_i)
      begin
        if (sys_rst_i)
        begin
          // idle high like the pulled-up pins, no false edge
          meta_r[g] <= 1'b1;
          sync_r[g] <= 1'b1;
        end
        else
        begin
          meta_r[g] <= async_i[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_r;

endmodule

`default_nettype wire

// ### core/bir_board_irq_router.sv
// multipurpose pin port with per lane interrupts steered to two processors
`timescale 1ns/100ps
`default_nettype none

module bir_board_irq_router
  import bir_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  var  bir_bus_req_t      bus_req_i,
  output logic      [PORT_W-1:0] rdata_o,
  input  wire logic [PORT_W-1:0] multipurpose_pin_port_i,
  output logic      [PORT_W-1:0] multipurpose_pin_port_o,
  output logic      [PORT_W-1:0] multipurpose_pin_port_oe_n_o,
  output logic                   primary_cpu_irq_out_n_o,
  output logic                   secondary_cpu_irq_out_n_o
);

  // ==========================================================
  // state and helpers
  bir_state_t        s_r;
  bir_state_t        s_nxt;
  logic [PORT_W-1:0] pin_sync;

  // ==========================================================
  // pin synchroniser
  bir_sync2
  #(
    .WIDTH   (PORT_W)
  )
  u_sync
  (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (multipurpose_pin_port_i),
    .sync_o    (pin_sync)
  );

  // ==========================================================
  // register read decode
  function automatic logic [PORT_W-1:0] rd_decode(input bir_state_t        st,
                                                  input logic [PORT_W-1:0] pins,
                                                  input logic [ADDR_W-1:0] addr);
    logic [PORT_W-1:0] steer;
    steer = RD_ZERO;
    steer[STEER_PRI_LSB +: LANES] = st.pri;
    steer[STEER_SEC_LSB +: LANES] = st.sec;
    case (addr)
      OFS_DIR:   rd_decode = st.dir;
      OFS_OUT:   rd_decode = st.dout;
      OFS_PIN:   rd_decode = pins;
      OFS_IEN:   rd_decode = st.ien;
      OFS_POL:   rd_decode = st.pol;
      OFS_TRIG:  rd_decode = st.trig;
      OFS_CAUSE: rd_decode = st.cause;
      OFS_LANE:  rd_decode = {{(PORT_W-LANES){1'b0}}, st.lane};
      OFS_STEER: rd_decode = steer;
      default:   rd_decode = RD_ZERO;
    endcase
  endfunction

  // ==========================================================
  // next state
  logic [PORT_W-1:0] act_now;
  logic [PORT_W-1:0] act_prev;
  logic [PORT_W-1:0] edge_hit;
  logic [PORT_W-1:0] cond;
  logic [PORT_W-1:0] set_bits;
  logic [PORT_W-1:0] clr_bits;
  logic [PORT_W-1:0] steer_wr;
  logic [PORT_W-1:0] steer_old;
  logic [PORT_W-1:0] live;

  always_comb
  begin
    s_nxt = s_r;

    act_now  = pin_sync ^ s_r.pol;
    act_prev = s_r.prev ^ s_r.pol;
    edge_hit = act_now & ~act_prev;
    // doorbell pin 4 from processor two defaults to falling edge
    // same for the pin of processor one
    cond     = (s_r.trig & edge_hit) | (~s_r.trig & act_now);
    set_bits = cond & s_r.ien;
    s_nxt.prev = pin_sync;

    clr_bits = RD_ZERO;
    steer_old = RD_ZERO;
    steer_old[STEER_PRI_LSB +: LANES] = s_r.pri;
    steer_old[STEER_SEC_LSB +: LANES] = s_r.sec;
    steer_wr = bir_merge(steer_old, bus_req_i.wdata, bus_req_i.be);

    if (bus_req_i.wr)
    begin
      case (bus_req_i.addr)
        OFS_DIR:
        begin
          s_nxt.dir = bir_merge(s_r.dir, bus_req_i.wdata, bus_req_i.be);
        end
        OFS_OUT:
        begin
          s_nxt.dout = bir_merge(s_r.dout, bus_req_i.wdata, bus_req_i.be);
        end
        OFS_IEN:
        begin
          s_nxt.ien = bir_merge(s_r.ien, bus_req_i.wdata, bus_req_i.be);
        end
        OFS_POL:
        begin
          s_nxt.pol = bir_merge(s_r.pol, bus_req_i.wdata, bus_req_i.be);
        end
        OFS_TRIG:
        begin
          s_nxt.trig = bir_merge(s_r.trig, bus_req_i.wdata, bus_req_i.be);
        end
        OFS_CAUSE:
        begin
          clr_bits = bus_req_i.wdata & bir_lane_mask(bus_req_i.be);
        end
        OFS_STEER:
        begin
          s_nxt.pri = steer_wr[STEER_PRI_LSB +: LANES];
          s_nxt.sec = steer_wr[STEER_SEC_LSB +: LANES];
        end
        default:
        begin
          s_nxt.dir = s_r.dir;
        end
      endcase
    end

    // sticky cause, set wins over clear
    s_nxt.cause = (s_r.cause & ~clr_bits) | set_bits;

    live = s_nxt.cause & s_nxt.ien;
    for (int i = 0; i < LANES; i++)
    begin
      s_nxt.lane[i] = |live[i*8 +: 8];
    end

    s_nxt.irq_pri = |(s_nxt.lane & s_nxt.pri);
    s_nxt.irq_sec = |(s_nxt.lane & s_nxt.sec);

    // read data valid only in the cycle after the strobe
    if (bus_req_i.rd)
    begin
      s_nxt.rdata = rd_decode(s_r, pin_sync, bus_req_i.addr);
    end
    else
    begin
      s_nxt.rdata = RD_ZERO;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      s_r.dir     <= RST_DIR;
      s_r.dout    <= RST_OUT;
      s_r.ien     <= RST_IEN;
      s_r.pol     <= RST_POL;
      s_r.trig    <= RST_TRIG;
      s_r.cause   <= RD_ZERO;
      s_r.prev    <= RST_PIN;
      s_r.lane    <= '0;
      s_r.pri     <= RST_PRI;
      s_r.sec     <= RST_SEC;
      s_r.rdata   <= RD_ZERO;
      s_r.irq_pri <= 1'b0;
      s_r.irq_sec <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  // pin 5 driven when set as output
  assign multipurpose_pin_port_o      = s_r.dout;
  assign multipurpose_pin_port_oe_n_o = ~s_r.dir;
  assign rdata_o                      = s_r.rdata;
  assign primary_cpu_irq_out_n_o      = ~s_r.irq_pri;
  assign secondary_cpu_irq_out_n_o    = ~s_r.irq_sec;

endmodule

`default_nettype wire

// ### testbench/bir_router_chk.sv
// port checker of the board interrupt router
`timescale 1ns/100ps
`default_nettype none

module bir_router_chk
  import bir_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  var  bir_bus_req_t      bus_req_i,
  input  wire logic [PORT_W-1:0] rdata_o,
  input  wire logic [PORT_W-1:0] multipurpose_pin_port_o,
  input  wire logic [PORT_W-1:0] multipurpose_pin_port_oe_n_o,
  input  wire logic              primary_cpu_irq_out_n_o,
  input  wire logic              secondary_cpu_irq_out_n_o
);
  wire logic [PORT_W-1:0] oe_w   = multipurpose_pin_port_oe_n_o;
  wire logic [PORT_W-1:0] out_w  = multipurpose_pin_port_o;
  wire logic              wr_dir = bus_req_i.wr && bus_req_i.addr == OFS_DIR;
  wire logic              wr_out = bus_req_i.wr && bus_req_i.addr == OFS_OUT;

  // ==========================================================
  // assertions
  default clocking dc @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  a_rd_idle: assert property (!bus_req_i.rd |=> rdata_o == RD_ZERO)
    else $error("read data not zero outside a read");
  a_rd_unmapped: assert property (bus_req_i.rd && bus_req_i.addr[7:6] != 2'b00 |=> rdata_o == RD_ZERO)
    else $error("unmapped read not zero");
  a_dir_low_byte: assert property (wr_dir && bus_req_i.be[0] |=> oe_w[7:0] == ~$past(bus_req_i.wdata[7:0]))
    else $error("lane 0 direction not taken");
  a_dir_top_keep: assert property (!(wr_dir && bus_req_i.be[3]) |=> $stable(oe_w[31:24]))
    else $error("lane 3 direction changed");
  a_out_top_byte: assert property (wr_out && bus_req_i.be[3] |=> out_w[31:24] == $past(bus_req_i.wdata[31:24]))
    else $error("lane 3 output not taken");
  a_out_low_keep: assert property (!(wr_out && bus_req_i.be[0]) |=> $stable(out_w[7:0]))
    else $error("lane 0 output changed");
  a_rst_pins: assert property (disable iff (1'b0) $fell(sys_rst_i) |-> oe_w == '1 && out_w == RST_OUT)
    else $error("pins not released after reset");
  a_rst_irq_idle: assert property (disable iff (1'b0) $fell(sys_rst_i) |-> primary_cpu_irq_out_n_o
    && secondary_cpu_irq_out_n_o && rdata_o == RD_ZERO)
    else $error("outputs not idle after reset");
endmodule

bind bir_board_irq_router bir_router_chk u_bir_router_chk (
  .clock_i(clock_i),
  .sys_rst_i(sys_rst_i),
  .bus_req_i(bus_req_i),
  .rdata_o(rdata_o),
  .multipurpose_pin_port_o(multipurpose_pin_port_o),
  .multipurpose_pin_port_oe_n_o(multipurpose_pin_port_oe_n_o),
  .primary_cpu_irq_out_n_o(primary_cpu_irq_out_n_o),
  .secondary_cpu_irq_out_n_o(secondary_cpu_irq_out_n_o)
);

`default_nettype wire

// ### testbench/bir_board_model.sv
// board wiring seen by the pin port: pull-ups, sources, doorbell loops
`timescale 1ns/100ps
`default_nettype none

module bir_board_model
  import bir_pkg::*;
(
  input  wire logic [PORT_W-1:0] pin_o_i,
  input  wire logic [PORT_W-1:0] oe_n_i,
  input  wire logic [PORT_W-1:0] src_i,
  output logic      [PORT_W-1:0] pin_i_o
);
  logic [PORT_W-1:0] net_w;

  always_comb
  begin
    net_w = src_i;
    net_w[PIN_DOORBELL_FROM_CPU1] = pin_o_i[PIN_DOORBELL_TO_CPU2] | oe_n_i[PIN_DOORBELL_TO_CPU2];
    net_w[PIN_DOORBELL_FROM_CPU2] = pin_o_i[PIN_DOORBELL_TO_CPU1] | oe_n_i[PIN_DOORBELL_TO_CPU1];
    pin_i_o = (pin_o_i & ~oe_n_i) | (net_w & oe_n_i);
  end
endmodule

`default_nettype wire

// ### testbench/bir_board_irq_router_test.sv
// self-checking bench of the board interrupt router
`timescale 1ns/100ps
`default_nettype none

module bir_board_irq_router_test;
  import bir_pkg::*;
  logic              clock_i   = 1'b0;
  logic              sys_rst_i = 1'b1;
  bir_bus_req_t      req       = '0;
  logic [PORT_W-1:0] src       = '1;
  logic [PORT_W-1:0] rdata;
  logic [PORT_W-1:0] pin_o;
  logic [PORT_W-1:0] oe_n;
  logic [PORT_W-1:0] pin_i;
  logic              irq_p;
  logic              irq_s;
  logic [PORT_W-1:0] exp_q[$];
  logic              rd_seen   = 1'b0;
  logic [31:0]       seed      = 32'h0000_0058;
  int                fails     = 0;
  int                tests_run = 0;
  int                cyc       = 0;
  logic [31:0]       db_lo[2]  = '{32'h0000_00DF, 32'h7FFF_FFFF};
  logic [31:0]       db_c[2]   = '{32'h4000_0000, 32'h0000_0010};
  logic [31:0]       db_ln[2]  = '{32'h0000_0008, 32'h0000_0001};
  logic [3:0]        db_be[2]  = '{4'h1, 4'h8};

  always #2 clock_i = ~clock_i;

  bir_board_irq_router u_bir_board_irq_router (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_req_i(req), .rdata_o(rdata),
    .multipurpose_pin_port_i(pin_i), .multipurpose_pin_port_o(pin_o),
    .multipurpose_pin_port_oe_n_o(oe_n), .primary_cpu_irq_out_n_o(irq_p),
    .secondary_cpu_irq_out_n_o(irq_s));
  bir_board_model u_bir_board_model (.pin_o_i(pin_o), .oe_n_i(oe_n), .src_i(src), .pin_i_o(pin_i));

  // ==========================================================
  // tasks
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: 32'h0000_0000};
    exp_q.push_back(e);
    @(posedge clock_i);
  endtask

  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clock_i);
  endtask

  // waits for the active low pair {primary, secondary}
  task automatic expect_irq(input logic [1:0] w);
    req <= '0;
    @(negedge clock_i);
    for (int i = 0; i < 8 && {irq_p, irq_s} !== w; i++)
      @(negedge clock_i);
    check({30'h0, irq_p, irq_s}, {30'h0, w});
    @(posedge clock_i);
  endtask

  // ==========================================================
  // read data monitor and timeout
  always @(posedge clock_i)
    rd_seen <= req.rd;

  always @(negedge clock_i)
    if (rd_seen)
      check(rdata, exp_q.pop_front());

  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      fails++;
      finish_test();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    int p;
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rd(OFS_DIR, RST_DIR);
    rd(OFS_OUT, 32'hFFFF_FFFF);
    rd(OFS_PIN, 32'hFFFF_FFFF);
    rd(OFS_IEN, RST_IEN);
    rd(OFS_POL, 32'h4000_FFD0);
    rd(OFS_TRIG, 32'h4040_0010);
    rd(OFS_STEER, 32'h0000_0807);
    wr(8'h40, 4'hF, xs(seed));
    rd(8'h40, RD_ZERO);
    // each processor's doorbell sets the other processor's lane
    wr(OFS_DIR, 4'h1, 32'h0000_0020);
    wr(OFS_DIR, 4'h8, 32'h8000_0000);
    wr(OFS_IEN, 4'h1, 32'h0000_0010);
    wr(OFS_IEN, 4'h8, 32'h4000_0000);
    idle(2);
    for (int s = 0; s < 2; s++)
    begin
      for (int k = 0; k < 2; k++)
      begin
        wr(OFS_OUT, db_be[k], db_lo[k]);
        wr(OFS_OUT, db_be[k], 32'hFFFF_FFFF);
        expect_irq((s == k) ? 2'b10 : 2'b01);
        rd(OFS_CAUSE, db_c[k]);
        rd(OFS_LANE, db_ln[k]);
        wr(OFS_CAUSE, db_be[1-k], db_c[k]);
        expect_irq(2'b11);
      end
      wr(OFS_STEER, 4'hF, 32'h0000_0708);
    end
    wr(OFS_IEN, 4'h7, 32'h0040_FFC0);
    for (int n = 0; n < 4; n++)
    begin
      seed = xs(seed);
      p = 6 + int'(seed % 10);
      src[p] <= 1'b0;
      expect_irq(2'b10);
      rd(OFS_PIN, ~(32'h1 << p));
      rd(OFS_LANE, 32'h1 << (p / 8));
      wr(OFS_CAUSE, 4'hF, 32'hFFFF_FFFF);
      rd(OFS_CAUSE, 32'h1 << p);
      src[p] <= 1'b1;
      idle(4);
      wr(OFS_CAUSE, 4'hF, 32'hFFFF_FFFF);
      expect_irq(2'b11);
    end
    src[PIN_SOUTHBRIDGE] <= 1'b0;
    idle(6);
    expect_irq(2'b11);
    src[PIN_SOUTHBRIDGE] <= 1'b1;
    expect_irq(2'b10);
    rd(OFS_CAUSE, 32'h0040_0000);
    wr(OFS_CAUSE, 4'h4, 32'h0040_0000);
    expect_irq(2'b11);
    finish_test();
  end
endmodule

`default_nettype wire
